// [logic/tarc_trip_auto_reset.sv]
// Trip auto-reset controller: waits, issues internal resets, raises alarm.
// Assumes trip and cause inputs are synchronous to i_mclk and that
// i_tick_100ms pulses for one cycle every 0.1 s.
// What this block does
// R1: A resettable trip with retries enabled starts a reset attempt and keeps the alarm off.
// R2: Each reset is issued after the set interval (0.5 s to 600.0 s) measured from trip entry.
// R3: The retry count is disabled or 1 to 20, and attempts never exceed it.
// R4: A retry count of zero makes every trip a plain alarm with no reset attempt.
// R5: When trips recur beyond the retry count the alarm is raised and retries stop.
// R6: Only the nine listed trip causes may be auto-reset; any other alarms at once.
// R7: A retry-in-progress status is given and routed to a digital output by function 26.
// R8: The attempt counter clears once the drive runs normally after a reset.
`timescale 1ns/1ps
module tarc_trip_auto_reset (
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	input  wire logic        i_tick_100ms,
	input  wire logic        i_trip,
	input  wire logic [3:0]  i_trip_cause,
	input  wire logic        i_running_ok,
	input  wire logic        i_alarm_clear,
	input  wire logic [4:0]  i_retry_count_setting,
	input  wire logic [12:0] i_retry_interval_setting,
	input  wire logic [7:0]  i_out_func_select,
	output logic             o_reset_cmd,
	output logic             o_fault_alarm_output,
	output logic             o_retry_in_progress_output,
	output logic             o_digital_out
);
	tarc_pkg::tarc_state_t state;
	logic [4:0]  attempts;
	logic [12:0] ticks;

	function automatic logic cause_resettable(input logic [3:0] c);
		return c inside {tarc_pkg::CAUSE_OVERCURRENT, tarc_pkg::CAUSE_OVERVOLTAGE,
			tarc_pkg::CAUSE_HEATSINK_HOT, tarc_pkg::CAUSE_INTERNAL_HOT,
			tarc_pkg::CAUSE_DRIVE_OVLD, tarc_pkg::CAUSE_UNDERVOLTAGE,
			tarc_pkg::CAUSE_MOTOR_HOT, tarc_pkg::CAUSE_EXT_ALARM,
			tarc_pkg::CAUSE_MOTOR_OVLD};
	endfunction

	function automatic logic [12:0] clamp_interval(input logic [12:0] v);
		if (v < tarc_pkg::INTERVAL_MIN)
			return tarc_pkg::INTERVAL_MIN;
		if (v > tarc_pkg::INTERVAL_MAX)
			return tarc_pkg::INTERVAL_MAX;
		return v;
	endfunction

	// Settings above 20 are held to 20 so a bad setting cannot retry forever
	logic [4:0] limit;
	assign limit = (i_retry_count_setting > tarc_pkg::RETRY_COUNT_MAX) ?
		tarc_pkg::RETRY_COUNT_MAX : i_retry_count_setting; // R3

	logic may_retry;
	assign may_retry = (limit != tarc_pkg::RETRY_DISABLED) // R4
		&& cause_resettable(i_trip_cause) // R6
		&& (attempts < limit); // R3 R5

	// The interval ends on the tick that completes the set count of 0.1 s steps
	logic interval_done;
	assign interval_done = i_tick_100ms
		&& (ticks + 13'h0001 >= clamp_interval(i_retry_interval_setting)); // R2

	// The first restart cycle still shows the old trip, so it is not counted again
	logic trip_again;
	assign trip_again = i_trip && !o_reset_cmd; // R5

	// Recovery needs a clean run with no fresh trip pending
	logic recovered;
	assign recovered = state == tarc_pkg::TARC_RESTART && !trip_again && i_running_ok; // R8

	logic retrying;
	assign retrying = state == tarc_pkg::TARC_WAIT || state == tarc_pkg::TARC_RESTART; // R7

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			state <= tarc_pkg::TARC_IDLE;
		end else begin
			unique case (state)
				tarc_pkg::TARC_IDLE: begin
					if (i_trip)
						state <= may_retry ? tarc_pkg::TARC_WAIT : tarc_pkg::TARC_ALARM; // R1 R5
				end
				tarc_pkg::TARC_WAIT: begin
					if (interval_done)
						state <= tarc_pkg::TARC_RESTART; // R2
				end
				tarc_pkg::TARC_RESTART: begin
					// A recurring trip is judged again against the attempt limit
					if (trip_again)
						state <= may_retry ? tarc_pkg::TARC_WAIT : tarc_pkg::TARC_ALARM; // R5
					else if (i_running_ok)
						state <= tarc_pkg::TARC_IDLE; // R8
				end
				tarc_pkg::TARC_ALARM: begin
					// Leaves only on an external alarm clear with the trip gone
					if (i_alarm_clear && !i_trip)
						state <= tarc_pkg::TARC_IDLE;
				end
			endcase
		end
	end

	// Interval timer, restarted on every trip entry
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			ticks <= 13'h0000;
		end else if (state != tarc_pkg::TARC_WAIT) begin
			ticks <= 13'h0000;
		end else if (i_tick_100ms) begin
			ticks <= ticks + 13'h0001; // R2
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			attempts <= 5'h00;
		end else if (state == tarc_pkg::TARC_IDLE || state == tarc_pkg::TARC_ALARM) begin
			attempts <= 5'h00;
		end else if (recovered) begin
			attempts <= 5'h00; // R8
		end else if (state == tarc_pkg::TARC_WAIT && interval_done) begin
			attempts <= attempts + 5'h01; // R3
		end
	end

	// Reset command is a one-cycle pulse on entry to restart
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_reset_cmd <= 1'b0;
		end else begin
			o_reset_cmd <= state == tarc_pkg::TARC_WAIT && interval_done; // R2
		end
	end

	// Alarm stays up until cleared, so monitoring cannot miss it
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_fault_alarm_output <= 1'b0;
		end else begin
			o_fault_alarm_output <= state == tarc_pkg::TARC_ALARM; // R1 R5 R6
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_retry_in_progress_output <= 1'b0;
		end else begin
			o_retry_in_progress_output <= retrying; // R7
		end
	end

	// Terminal follows the retry status only when its function selects it
	always_ff @(posedge i_mclk or posedge i_reset) begin
		if (i_reset) begin
			o_digital_out <= 1'b0;
		end else begin
			o_digital_out <= (i_out_func_select == tarc_pkg::OUT_FUNC_RETRY) && retrying; // R7
		end
	end

	a_disabled_alarms: assert property (@(posedge i_mclk) disable iff (i_reset) // R4
		state == tarc_pkg::TARC_IDLE && i_trip && i_retry_count_setting == 5'h00
		|=> state == tarc_pkg::TARC_ALARM)
		else $error("trip with retries disabled did not alarm");
	a_bad_cause_alarm: assert property (@(posedge i_mclk) disable iff (i_reset) // R6
		state == tarc_pkg::TARC_IDLE && i_trip && !cause_resettable(i_trip_cause)
		|=> state == tarc_pkg::TARC_ALARM)
		else $error("non-resettable trip did not alarm");
	a_no_alarm_retry: assert property (@(posedge i_mclk) disable iff (i_reset) // R1
		state == tarc_pkg::TARC_WAIT |=> !o_fault_alarm_output)
		else $error("alarm raised during retry");
	a_attempt_limit: assert property (@(posedge i_mclk) disable iff (i_reset) // R3
		attempts <= tarc_pkg::RETRY_COUNT_MAX)
		else $error("attempt count above limit");
	a_reset_timing: assert property (@(posedge i_mclk) disable iff (i_reset) // R2
		$rose(o_reset_cmd) |-> $past(state) == tarc_pkg::TARC_WAIT
		&& $past(ticks) + 13'h0001 >= tarc_pkg::INTERVAL_MIN)
		else $error("reset issued before interval");
	a_exhaust_alarm: assert property (@(posedge i_mclk) disable iff (i_reset) // R5
		state == tarc_pkg::TARC_RESTART && i_trip && !o_reset_cmd && attempts >= limit
		|=> state == tarc_pkg::TARC_ALARM ##1 o_fault_alarm_output)
		else $error("exhausted retries did not alarm");
	a_recover_clear: assert property (@(posedge i_mclk) disable iff (i_reset) // R8
		state == tarc_pkg::TARC_RESTART && !i_trip && i_running_ok
		|=> state == tarc_pkg::TARC_IDLE && attempts == 5'h00)
		else $error("attempt counter not cleared after recovery");
	a_retry_status: assert property (@(posedge i_mclk) disable iff (i_reset) // R7
		state == tarc_pkg::TARC_WAIT |=> o_retry_in_progress_output)
		else $error("retry status missing");

	// Checks below look only at the block's own state and pins
	a_reset_one_cycle: assert property (@(posedge i_mclk) disable iff (i_reset) // R2
		o_reset_cmd |=> !o_reset_cmd)
		else $error("reset command longer than one cycle");

	a_interval_reset: assert property (@(posedge i_mclk) disable iff (i_reset) // R2
		state == tarc_pkg::TARC_WAIT && i_tick_100ms
		&& ticks + 13'h0001 >= clamp_interval(i_retry_interval_setting)
		|=> state == tarc_pkg::TARC_RESTART && o_reset_cmd)
		else $error("interval end did not issue a reset");

	a_no_early_reset: assert property (@(posedge i_mclk) disable iff (i_reset) // R2
		state == tarc_pkg::TARC_WAIT && !i_tick_100ms |=> !o_reset_cmd)
		else $error("reset issued between ticks");

	a_retry_start: assert property (@(posedge i_mclk) disable iff (i_reset) // R1
		state == tarc_pkg::TARC_IDLE && i_trip
		&& i_retry_count_setting != tarc_pkg::RETRY_DISABLED
		&& cause_resettable(i_trip_cause)
		|=> state == tarc_pkg::TARC_WAIT
		##1 o_retry_in_progress_output && !o_fault_alarm_output)
		else $error("resettable trip did not start a retry");

	a_idle_no_attempts: assert property (@(posedge i_mclk) disable iff (i_reset) // R8
		state == tarc_pkg::TARC_IDLE |-> attempts == 5'h00)
		else $error("attempt count left over in idle");

	a_alarm_latched: assert property (@(posedge i_mclk) disable iff (i_reset) // R5
		state == tarc_pkg::TARC_ALARM && !(i_alarm_clear && !i_trip)
		|=> state == tarc_pkg::TARC_ALARM)
		else $error("alarm left without a clear");

	a_alarm_no_reset: assert property (@(posedge i_mclk) disable iff (i_reset) // R5
		state == tarc_pkg::TARC_ALARM |=> !o_reset_cmd && !o_retry_in_progress_output)
		else $error("reset or retry status while alarmed");

	a_idle_quiet: assert property (@(posedge i_mclk) disable iff (i_reset) // R7
		state == tarc_pkg::TARC_IDLE |=> !o_retry_in_progress_output && !o_fault_alarm_output)
		else $error("status raised while idle");

	a_terminal_route: assert property (@(posedge i_mclk) disable iff (i_reset) // R7
		o_digital_out == ($past(i_out_func_select) == tarc_pkg::OUT_FUNC_RETRY
		&& o_retry_in_progress_output))
		else $error("terminal does not follow the retry status");
endmodule

// [logic/tarc_pkg.sv]
// Constants for the trip auto-reset controller.
// Assumes a 250 MHz core clock and a free-running 0.1 s tick input.
package tarc_pkg;
	// Core clock period in ns
	localparam int CLK_PERIOD_NS = 4;
	// Retry count setting: 0 disables, 1 to 20 attempts
	localparam logic [4:0] RETRY_DISABLED  = 5'h00;
	localparam logic [4:0] RETRY_COUNT_MAX = 5'h14;
	// Interval setting in 0.1 s units: 0.5 s to 600.0 s
	localparam logic [12:0] INTERVAL_MIN = 13'h0005;
	localparam logic [12:0] INTERVAL_MAX = 13'h1770;
	// Trip cause codes
	localparam int CAUSE_W = 4;
	localparam logic [3:0] CAUSE_OVERCURRENT   = 4'h1;
	localparam logic [3:0] CAUSE_OVERVOLTAGE   = 4'h2;
	localparam logic [3:0] CAUSE_HEATSINK_HOT  = 4'h3;
	localparam logic [3:0] CAUSE_INTERNAL_HOT  = 4'h4;
	localparam logic [3:0] CAUSE_DRIVE_OVLD    = 4'h5;
	localparam logic [3:0] CAUSE_UNDERVOLTAGE  = 4'h6;
	localparam logic [3:0] CAUSE_MOTOR_HOT     = 4'h7;
	localparam logic [3:0] CAUSE_EXT_ALARM     = 4'h8;
	localparam logic [3:0] CAUSE_MOTOR_OVLD    = 4'h9;
	// Output function selection value that routes the retry status
	localparam logic [7:0] OUT_FUNC_RETRY = 8'h1A;

	typedef enum logic [1:0] {
		TARC_IDLE    = 2'b00,
		TARC_WAIT    = 2'b01,
		TARC_RESTART = 2'b10,
		TARC_ALARM   = 2'b11
	} tarc_state_t;
endpackage

// [bench/tarc_drive_model.sv]
// Drive protection model: trips on request and answers reset commands.
// Assumes the controller's outputs are registered on i_mclk.
`timescale 1ns/1ps
module tarc_drive_model (
	input  wire logic       i_mclk,
	input  wire logic       i_start,
	input  wire logic       i_stop,
	input  wire logic       i_fail,
	input  wire logic [3:0] i_cause,
	input  wire logic       i_reset_cmd,
	output logic            o_trip,
	output logic [3:0]      o_trip_cause,
	output logic            o_running_ok
);
	logic [1:0] retrip;
	// Cause is only meaningful while tripped, so it is scrambled otherwise
	assign o_trip_cause = o_trip ? i_cause : ~i_cause;
	always_ff @(posedge i_mclk) begin
		retrip <= i_stop ? 2'h0 : {retrip[0], i_reset_cmd & i_fail};
		if (i_stop | i_reset_cmd) begin
			o_trip <= 1'b0;
			o_running_ok <= ~i_stop & ~i_fail;
		end else if (i_start | retrip[1]) begin
			o_trip <= 1'b1;
			o_running_ok <= 1'b0;
		end
	end
endmodule

// [bench/tarc_trip_auto_reset_tb_top.sv]
// Bench for the trip auto-reset controller against a drive model.
// Assumes a 4 ns clock; a tick every ten clocks stands in for 0.1 s.
`timescale 1ns/1ps
module tarc_trip_auto_reset_tb_top;
	logic i_mclk = 0, i_reset = 1, tick = 0, start = 0, stop = 1, fail = 0, clr = 0;
	logic [3:0] cause = 4'h1, tcause, tk = 4'h0;
	logic [4:0] cnt = 5'h03;
	logic [12:0] ivl = tarc_pkg::INTERVAL_MIN;
	logic [7:0] sel = tarc_pkg::OUT_FUNC_RETRY;
	logic trip, ok, rcmd, alarm, retry, dout;
	int miscompares = 0, checks_done = 0, resets, first;
	always #2 i_mclk = ~i_mclk;
	// A fast tick keeps the run short; every interval scales with it
	always @(posedge i_mclk) begin
		#1 tk = (tk == 4'h9) ? 4'h0 : tk + 4'h1;
		tick = (tk == 4'h0);
	end
	tarc_trip_auto_reset tarc_trip_auto_reset_i (.i_mclk(i_mclk), .i_reset(i_reset),
		.i_tick_100ms(tick), .i_trip(trip), .i_trip_cause(tcause), .i_running_ok(ok),
		.i_alarm_clear(clr), .i_retry_count_setting(cnt), .i_retry_interval_setting(ivl),
		.i_out_func_select(sel), .o_reset_cmd(rcmd), .o_fault_alarm_output(alarm),
		.o_retry_in_progress_output(retry), .o_digital_out(dout));
	tarc_drive_model tarc_drive_model_i (.i_mclk(i_mclk), .i_start(start), .i_stop(stop),
		.i_fail(fail), .i_cause(cause), .i_reset_cmd(rcmd), .o_trip(trip),
		.o_trip_cause(tcause), .o_running_ok(ok));
	task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic run(input logic [3:0] c, input logic [4:0] k, input logic f,
		input logic [15:0] er, input logic ea);
		int nt;
		logic routed;
		nt = (ivl < tarc_pkg::INTERVAL_MIN) ? int'(tarc_pkg::INTERVAL_MIN) : int'(ivl);
		routed = (sel == tarc_pkg::OUT_FUNC_RETRY);
		cause = c;
		cnt = k;
		fail = f;
		start = 1;
		resets = 0;
		first = 0;
		@(posedge i_mclk) #1 start = 0;
		for (int n = 1; n < 1300; n++) begin
			@(posedge i_mclk) #1;
			if (rcmd === 1'b1 && first == 0) first = n;
			if (rcmd === 1'b1) resets++;
			if (n == 2) begin
				check("retry_flag", {15'h0000, retry}, {15'h0000, er != 0});
				check("terminal", {15'h0000, dout}, {15'h0000, er != 0 && routed});
				check("early_alarm", {15'h0000, alarm}, {15'h0000, er == 0});
			end
		end
		// Ten clocks per tick; the first tick after trip entry may fall anywhere in a period
		if (er != 0) check("interval", {15'h0000, first >= 10 * nt - 8}, 16'h0001);
		if (er != 0) check("interval_end", {15'h0000, first <= 10 * nt + 1}, 16'h0001);
		check("resets", resets[15:0], er);
		check("alarm", {15'h0000, alarm}, {15'h0000, ea});
		check("retry_end", {15'h0000, retry}, 16'h0000);
		stop = 1;
		clr = 1;
		repeat (3) @(posedge i_mclk);
		#1 clr = 0;
		stop = 0;
	endtask
	task automatic each_cause_recovers;
		for (int c = 1; c <= 9; c++) run(c[3:0], 5'h01, 0, 16'h0001, 0);
	endtask
	task automatic three_attempts_then_alarm;
		sel = 8'h19;
		run(4'h2, 5'h03, 1, 16'h0003, 1);
		sel = tarc_pkg::OUT_FUNC_RETRY;
	endtask
	task automatic twenty_attempts_then_alarm;
		run(4'h9, 5'h14, 1, 16'h0014, 1);
		run(4'h9, 5'h1F, 1, 16'h0014, 1);
	endtask
	task automatic interval_settings;
		ivl = 13'h0008;
		run(4'h5, 5'h01, 0, 16'h0001, 0);
		ivl = 13'h0002;
		run(4'h6, 5'h01, 0, 16'h0001, 0);
		ivl = tarc_pkg::INTERVAL_MIN;
	endtask
	task automatic reset_mid_retry;
		cause = 4'h1;
		cnt = 5'h03;
		fail = 1;
		start = 1;
		@(posedge i_mclk) #1 start = 0;
		repeat (20) @(posedge i_mclk);
		#1 check("pre_reset", {15'h0000, retry}, 16'h0001);
		i_reset = 1;
		stop = 1;
		@(posedge i_mclk) #1;
		check("reset_retry", {15'h0000, retry}, 16'h0000);
		check("reset_alarm", {15'h0000, alarm}, 16'h0000);
		repeat (2) @(posedge i_mclk);
		#1 i_reset = 0;
		stop = 0;
		repeat (60) @(posedge i_mclk);
		#1 check("after_reset", {15'h0000, retry | alarm | rcmd}, 16'h0000);
	endtask
	task automatic disabled_and_foreign_cause;
		run(4'h3, 5'h00, 0, 16'h0000, 1);
		run(4'hA, 5'h03, 0, 16'h0000, 1);
	endtask
	task automatic summarize;
		if (miscompares == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge i_mclk);
		#1 i_reset = 0;
		stop = 0;
		each_cause_recovers();
		three_attempts_then_alarm();
		twenty_attempts_then_alarm();
		disabled_and_foreign_cause();
		interval_settings();
		reset_mid_retry();
		summarize();
	end
	// Scenarios need about 21000 clocks; this allows more than twice that
	initial begin
		#240000;
		miscompares++;
		summarize();
	end
endmodule
